// [core/fsdc_pkg.sv]
`default_nettype none
package fsdc_pkg;

    // ********************************************************
    // Widths
    // ********************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int OFS_W = 24;
    localparam int SUM_W = 25;

    typedef logic [ADDR_W-1:0] fsdc_addr_t;
    typedef logic [DATA_W-1:0] fsdc_word_t;
    typedef logic [OFS_W-1:0] fsdc_ofs_t;
    typedef logic [SUM_W-1:0] fsdc_sum_t;

    // ********************************************************
    // Register byte addresses
    // ********************************************************
    localparam fsdc_addr_t REG_CONTEXT = 8'h00;
    localparam fsdc_addr_t REG_OPTIONS = 8'h04;
    localparam fsdc_addr_t REG_TAG_OFS = 8'h08;
    localparam fsdc_addr_t REG_MACIN_OFS = 8'h0c;
    localparam fsdc_addr_t REG_ENC_OFS = 8'h10;
    localparam fsdc_addr_t REG_ENC_LEN = 8'h14;
    localparam fsdc_addr_t REG_MAC_OFS = 8'h18;
    localparam fsdc_addr_t REG_CTR_LIMIT = 8'h1c;
    localparam fsdc_addr_t REG_UID_OFS = 8'h20;
    localparam fsdc_addr_t REG_CTR_OFS = 8'h24;
    localparam fsdc_addr_t REG_FILE_LEN = 8'h28;
    localparam fsdc_addr_t REG_CUR_CTR = 8'h2c;
    localparam fsdc_addr_t REG_ACCESS = 8'h30;
    localparam fsdc_addr_t REG_START = 8'h34;
    localparam fsdc_addr_t REG_STATUS = 8'h38;
    localparam fsdc_addr_t REG_COMMITTED = 8'h3c;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int CTX_CHAIN_BIT = 0;
    localparam int CTX_SMFAIL_BIT = 1;
    localparam int CTX_AUTH_BIT = 2;
    localparam int CTX_DMEN_BIT = 3;
    localparam int CTX_FNO_LSB = 8;
    localparam int CTX_CHG_LSB = 16;
    localparam int OPT_DMR_LSB = 8;
    localparam int OPT_UID_BIT = 7;
    localparam int OPT_CTR_BIT = 6;
    localparam int OPT_LIM_BIT = 5;
    localparam int OPT_ENC_BIT = 4;
    localparam int DMR_META_LSB = 12;
    localparam int DMR_FREAD_LSB = 8;
    localparam int DMR_CTRRET_LSB = 0;
    localparam int STS_SW2_LSB = 8;
    localparam int STS_BUSY_BIT = 16;
    localparam int STS_PASS_BIT = 17;
    localparam int COM_DMR_LSB = 8;

    // ********************************************************
    // Codes and lengths
    // ********************************************************
    localparam logic [3:0] RIGHT_NONE = 4'hf;
    localparam logic [3:0] RIGHT_FREE = 4'he;
    localparam logic [3:0] KEY_MAX = 4'h4;
    localparam logic [4:0] DM_FILE_NO = 5'h02;
    localparam logic [7:0] SW1_FRAME = 8'h91;
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_ABORTED = 8'hca;
    localparam logic [7:0] ST_INTEGRITY = 8'h1e;
    localparam logic [7:0] ST_PARAM = 8'h9e;
    localparam logic [7:0] ST_DENIED = 8'h9d;
    localparam logic [7:0] ST_AUTH = 8'hae;
    localparam fsdc_sum_t MAC_LEN = 25'h000010;
    localparam fsdc_sum_t TAG_LEN = 25'h000020;
    localparam fsdc_sum_t UID_LEN = 25'h00000e;
    localparam fsdc_sum_t CTR_LEN = 25'h000006;
    localparam fsdc_sum_t ENC_MIN = 25'h000020;
    localparam fsdc_ofs_t ENC_ALIGN_MASK = 24'h00001f;
    localparam fsdc_ofs_t CTR_NO_MIRROR = 24'hffffff;
    localparam logic [15:0] RST_RIGHTS = 16'hffff;

    typedef enum logic [1:0] {
        FSDC_IDLE = 2'b00,
        FSDC_EVAL = 2'b01
    } fsdc_state_t;

    // One mirrored region of the file
    typedef struct packed {
        logic en;
        fsdc_sum_t ofs;
        fsdc_sum_t len;
    } fsdc_region_t;

endpackage : fsdc_pkg
`default_nettype wire

// [core/fsdc_overlap.sv]
`default_nettype none
// ********************************************************
// Region clash detector
// ********************************************************
module fsdc_overlap (
    input wire fsdc_pkg::fsdc_region_t a_i,
    input wire fsdc_pkg::fsdc_region_t b_i,
    output logic clash_o
);
    import fsdc_pkg::*;

    fsdc_sum_t a_end;
    fsdc_sum_t b_end;
    logic apart;

    // Sums one bit wider so an end near the top cannot wrap
    assign a_end = a_i.ofs + a_i.len;
    assign b_end = b_i.ofs + b_i.len;
    assign apart = (a_i.ofs >= b_end) || (b_i.ofs >= a_end);
    // Absent regions never clash
    assign clash_o = a_i.en && b_i.en && !apart;

endmodule : fsdc_overlap
`default_nettype wire

// [core/fsdc_checker.sv]
// How it works
// - Encrypted tag-data offset, 3 bytes, present for key 0-4, fits file.
// - MAC input offset present if file read right not F, at most MAC offset.
// - Encrypted region fields present with bit 4; length multiple of 32, fits.
// - Without encryption, MAC offset from MAC input to file length minus 16.
// - With encryption, MAC offset from encrypted end to file length minus 16.
// - Read counter limit present with bit 5, value must exceed present count.
// - Chained command still ongoing answers CAh.
// - Failed secure messaging MAC answers 1Eh.
// - Any access or dynamic messaging right naming a missing key answers 9Eh.
// - Metadata right not F needs identifier or counter mirroring.
// - Metadata right F forbids identifier mirroring.
// - Counter retrieval right not F needs counter mirroring.
// - MAC and identifier regions must not overlap.
// - MAC and read counter regions must not overlap.
// - MAC and tag-data regions must not overlap.
// - Encrypted data and identifier regions must not overlap.
// - Encrypted data and read counter regions must not overlap.
// - Identifier and read counter regions must not overlap.
// - Encryption needs file read right and both mirrorings enabled.
// - Counter limit needs counter mirroring and must exceed present count.
// - Dynamic messaging on a file other than 02h answers 9Dh.
// - Change right not F without authentication answers AEh.
`default_nettype none
module fsdc_checker (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire fsdc_pkg::fsdc_addr_t addr_i,
    input wire fsdc_pkg::fsdc_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic busy_o,
    output logic done_o,
    output logic commit_o,
    output logic [7:0] sw1_o,
    output logic [7:0] sw2_o
);
    import fsdc_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        fsdc_state_t fsm;
        logic chain;
        logic smfail;
        logic auth;
        logic dm_en;
        logic [4:0] file_no;
        logic [3:0] chg_right;
        logic [7:0] options;
        logic [15:0] dm_rights;
        logic [15:0] acc_rights;
        fsdc_ofs_t tag_ofs;
        fsdc_ofs_t macin_ofs;
        fsdc_ofs_t enc_ofs;
        fsdc_ofs_t enc_len;
        fsdc_ofs_t mac_ofs;
        fsdc_ofs_t ctr_limit;
        fsdc_ofs_t uid_ofs;
        fsdc_ofs_t ctr_ofs;
        fsdc_ofs_t file_len;
        fsdc_ofs_t cur_ctr;
        logic [7:0] com_options;
        logic [15:0] com_rights;
        logic busy;
        logic done;
        logic commit;
        logic pass;
        logic [7:0] sw1;
        logic [7:0] sw2;
        fsdc_word_t rdata;
    } fsdc_regs_t;

    fsdc_regs_t q;
    fsdc_regs_t d;

    // ********************************************************
    // Helpers
    // ********************************************************

    // Key exists or is F, or is E only when free_ok is set
    function automatic logic key_ok(input logic [3:0] r, input logic free_ok);
        logic ok;
        ok = (r <= KEY_MAX) || (r == RIGHT_NONE) || (free_ok && (r == RIGHT_FREE));
        return ok;
    endfunction : key_ok

    // All four nibbles of the general rights name real keys or one of the special codes
    function automatic logic acc_ok(input logic [15:0] r);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ok = ok && key_ok(r[4*i +: 4], 1'b1);
        end
        return ok;
    endfunction : acc_ok

    // Widen an offset for sums that must not wrap
    function automatic fsdc_sum_t wide(input fsdc_ofs_t v);
        return {1'b0, v};
    endfunction : wide

    // ********************************************************
    // Decoded fields
    // ********************************************************
    logic [3:0] meta_right;
    logic [3:0] fread_right;
    logic [3:0] ctrret_right;
    logic opt_uid;
    logic opt_ctr;
    logic opt_lim;
    logic opt_enc;
    logic tag_present;
    logic mac_present;
    logic enc_present;
    logic uid_present;
    logic ctr_present;

    assign meta_right = q.dm_rights[DMR_META_LSB +: 4];
    assign fread_right = q.dm_rights[DMR_FREAD_LSB +: 4];
    assign ctrret_right = q.dm_rights[DMR_CTRRET_LSB +: 4];
    assign opt_uid = q.options[OPT_UID_BIT];
    assign opt_ctr = q.options[OPT_CTR_BIT];
    assign opt_lim = q.options[OPT_LIM_BIT];
    assign opt_enc = q.options[OPT_ENC_BIT];

    // Presence of the optional fields
    // tag offset presence
    assign tag_present = q.dm_en && (meta_right <= KEY_MAX);
    assign mac_present = q.dm_en && (fread_right != RIGHT_NONE);
    assign enc_present = mac_present && opt_enc;
    assign uid_present = q.dm_en && opt_uid && (meta_right == RIGHT_FREE);
    // All ones in the counter offset means no counter mirror
    assign ctr_present = q.dm_en && opt_ctr && (meta_right == RIGHT_FREE)
                         && (q.ctr_ofs != CTR_NO_MIRROR);

    // ********************************************************
    // Region overlap checks
    // ********************************************************
    fsdc_region_t mac_reg;
    fsdc_region_t enc_reg;
    fsdc_region_t uid_reg;
    fsdc_region_t ctr_reg;
    fsdc_region_t tag_reg;
    logic [6:0] clash;

    assign mac_reg = '{en: mac_present, ofs: wide(q.mac_ofs), len: MAC_LEN};
    assign enc_reg = '{en: enc_present, ofs: wide(q.enc_ofs), len: wide(q.enc_len)};
    assign uid_reg = '{en: uid_present, ofs: wide(q.uid_ofs), len: UID_LEN};
    assign ctr_reg = '{en: ctr_present, ofs: wide(q.ctr_ofs), len: CTR_LEN};
    assign tag_reg = '{en: tag_present, ofs: wide(q.tag_ofs), len: TAG_LEN};

    fsdc_overlap u_mac_uid (.a_i(mac_reg), .b_i(uid_reg), .clash_o(clash[0]));
    fsdc_overlap u_mac_ctr (.a_i(mac_reg), .b_i(ctr_reg), .clash_o(clash[1]));
    fsdc_overlap u_mac_tag (.a_i(mac_reg), .b_i(tag_reg), .clash_o(clash[2]));
    fsdc_overlap u_enc_uid (.a_i(enc_reg), .b_i(uid_reg), .clash_o(clash[3]));
    fsdc_overlap u_enc_ctr (.a_i(enc_reg), .b_i(ctr_reg), .clash_o(clash[4]));
    fsdc_overlap u_enc_tag (.a_i(enc_reg), .b_i(tag_reg), .clash_o(clash[5]));
    fsdc_overlap u_uid_ctr (.a_i(uid_reg), .b_i(ctr_reg), .clash_o(clash[6]));

    // ********************************************************
    // Parameter checks
    // ********************************************************
    logic bad_keys;
    logic bad_rights;
    logic bad_range;
    logic bad_param;
    logic bad_denied;
    logic bad_auth;
    fsdc_sum_t flen;
    fsdc_sum_t enc_end;

    assign flen = wide(q.file_len);
    assign enc_end = wide(q.enc_ofs) + wide(q.enc_len);

    assign bad_keys = !acc_ok(q.acc_rights)
                      || (q.dm_en && !(key_ok(meta_right, 1'b1)
                                       && key_ok(fread_right, 1'b0)
                                       && key_ok(ctrret_right, 1'b1)));

    // Right combinations against the mirroring options
    always_comb begin
        bad_rights = 1'b0;
        if (q.dm_en) begin
            if ((meta_right != RIGHT_NONE) && !opt_uid && !opt_ctr) begin
                bad_rights = 1'b1;
            end
            if ((meta_right == RIGHT_NONE) && opt_uid) begin
                bad_rights = 1'b1;
            end
            if ((ctrret_right != RIGHT_NONE) && !opt_ctr) begin
                bad_rights = 1'b1;
            end
            if (opt_enc && ((fread_right == RIGHT_NONE) || !opt_uid || !opt_ctr)) begin
                bad_rights = 1'b1;
            end
            // counter limit sanity; value must exceed the current counter
            if (opt_lim && (!opt_ctr || (q.ctr_limit <= q.cur_ctr))) begin
                bad_rights = 1'b1;
            end
        end
    end

    // Offset ranges of each present field
    always_comb begin
        bad_range = 1'b0;
        if (tag_present && (tag_reg.ofs + TAG_LEN > flen)) begin
            bad_range = 1'b1;
        end
        if (uid_present && (uid_reg.ofs + UID_LEN > flen)) begin
            bad_range = 1'b1;
        end
        if (ctr_present && (ctr_reg.ofs + CTR_LEN > flen)) begin
            bad_range = 1'b1;
        end
        // MAC input not past MAC offset
        if (mac_present && (q.macin_ofs > q.mac_ofs)) begin
            bad_range = 1'b1;
        end
        if (enc_present && (((q.enc_len & ENC_ALIGN_MASK) != '0)
                            || (wide(q.enc_len) < ENC_MIN)
                            || (q.enc_ofs < q.macin_ofs)
                            || (enc_end > mac_reg.ofs))) begin
            bad_range = 1'b1;
        end
        if (mac_present && (mac_reg.ofs + MAC_LEN > flen)) begin
            bad_range = 1'b1;
        end
        if (enc_present && (mac_reg.ofs < enc_end)) begin
            bad_range = 1'b1;
        end
    end

    assign bad_param = bad_keys || bad_rights || bad_range || (clash != '0);
    assign bad_denied = (q.chg_right == RIGHT_NONE)
                        || (q.dm_en && (q.file_no != DM_FILE_NO));
    assign bad_auth = (q.chg_right != RIGHT_NONE) && !q.auth;

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        logic [7:0] code;
        code = ST_OK;
        d = q;
        d.done = 1'b0;
        d.commit = 1'b0;
        d.rdata = '0;

        // Register writes, ignored while a check runs
        if (wr_i && !q.busy) begin
            unique case (addr_i)
                REG_CONTEXT: begin
                    d.chain = wdata_i[CTX_CHAIN_BIT];
                    d.smfail = wdata_i[CTX_SMFAIL_BIT];
                    d.auth = wdata_i[CTX_AUTH_BIT];
                    d.dm_en = wdata_i[CTX_DMEN_BIT];
                    d.file_no = wdata_i[CTX_FNO_LSB +: 5];
                    d.chg_right = wdata_i[CTX_CHG_LSB +: 4];
                end
                REG_OPTIONS: begin
                    d.options = wdata_i[7:0];
                    d.dm_rights = wdata_i[OPT_DMR_LSB +: 16];
                end
                REG_TAG_OFS: d.tag_ofs = wdata_i[OFS_W-1:0];
                REG_MACIN_OFS: d.macin_ofs = wdata_i[OFS_W-1:0];
                REG_ENC_OFS: d.enc_ofs = wdata_i[OFS_W-1:0];
                REG_ENC_LEN: d.enc_len = wdata_i[OFS_W-1:0];
                REG_MAC_OFS: d.mac_ofs = wdata_i[OFS_W-1:0];
                REG_CTR_LIMIT: d.ctr_limit = wdata_i[OFS_W-1:0];
                REG_UID_OFS: d.uid_ofs = wdata_i[OFS_W-1:0];
                REG_CTR_OFS: d.ctr_ofs = wdata_i[OFS_W-1:0];
                REG_FILE_LEN: d.file_len = wdata_i[OFS_W-1:0];
                REG_CUR_CTR: d.cur_ctr = wdata_i[OFS_W-1:0];
                REG_ACCESS: d.acc_rights = wdata_i[15:0];
                REG_START: begin
                    d.fsm = FSDC_EVAL;
                    d.busy = 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Read data for the following cycle only; unmapped reads give zero
        if (rd_i) begin
            unique case (addr_i)
                REG_CONTEXT: begin
                    d.rdata[CTX_CHAIN_BIT] = q.chain;
                    d.rdata[CTX_SMFAIL_BIT] = q.smfail;
                    d.rdata[CTX_AUTH_BIT] = q.auth;
                    d.rdata[CTX_DMEN_BIT] = q.dm_en;
                    d.rdata[CTX_FNO_LSB +: 5] = q.file_no;
                    d.rdata[CTX_CHG_LSB +: 4] = q.chg_right;
                end
                REG_OPTIONS: begin
                    d.rdata[7:0] = q.options;
                    d.rdata[OPT_DMR_LSB +: 16] = q.dm_rights;
                end
                REG_TAG_OFS: d.rdata[OFS_W-1:0] = q.tag_ofs;
                REG_MACIN_OFS: d.rdata[OFS_W-1:0] = q.macin_ofs;
                REG_ENC_OFS: d.rdata[OFS_W-1:0] = q.enc_ofs;
                REG_ENC_LEN: d.rdata[OFS_W-1:0] = q.enc_len;
                REG_MAC_OFS: d.rdata[OFS_W-1:0] = q.mac_ofs;
                REG_CTR_LIMIT: d.rdata[OFS_W-1:0] = q.ctr_limit;
                REG_UID_OFS: d.rdata[OFS_W-1:0] = q.uid_ofs;
                REG_CTR_OFS: d.rdata[OFS_W-1:0] = q.ctr_ofs;
                REG_FILE_LEN: d.rdata[OFS_W-1:0] = q.file_len;
                REG_CUR_CTR: d.rdata[OFS_W-1:0] = q.cur_ctr;
                REG_ACCESS: d.rdata[15:0] = q.acc_rights;
                REG_STATUS: begin
                    d.rdata[7:0] = q.sw1;
                    d.rdata[STS_SW2_LSB +: 8] = q.sw2;
                    d.rdata[STS_BUSY_BIT] = q.busy;
                    d.rdata[STS_PASS_BIT] = q.pass;
                end
                REG_COMMITTED: begin
                    d.rdata[7:0] = q.com_options;
                    d.rdata[COM_DMR_LSB +: 16] = q.com_rights;
                end
                default: begin
                end
            endcase
        end

        // Verdict in priority order, one cycle after start
        unique case (q.fsm)
            FSDC_IDLE: begin
            end
            FSDC_EVAL: begin
                if (q.chain) begin
                    code = ST_ABORTED;
                end else if (q.smfail) begin
                    code = ST_INTEGRITY;
                end else if (bad_denied) begin
                    code = ST_DENIED;
                end else if (bad_auth) begin
                    code = ST_AUTH;
                end else if (bad_param) begin
                    code = ST_PARAM;
                end
                d.sw1 = SW1_FRAME;
                d.sw2 = code;
                d.pass = (code == ST_OK);
                if (code == ST_OK) begin
                    d.com_options = q.options;
                    d.com_rights = q.dm_rights;
                    d.commit = 1'b1;
                end
                d.done = 1'b1;
                d.busy = 1'b0;
                d.fsm = FSDC_IDLE;
            end
        endcase
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.com_rights <= RST_RIGHTS;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state flops
    assign rdata_o = q.rdata;
    assign busy_o = q.busy;
    assign done_o = q.done;
    assign commit_o = q.commit;
    assign sw1_o = q.sw1;
    assign sw2_o = q.sw2;

endmodule : fsdc_checker
`default_nettype wire

// [test/fsdc_checker_sva.sv]
`default_nettype none
module fsdc_checker_sva
    import fsdc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire fsdc_pkg::fsdc_addr_t addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic commit_o,
    input wire logic [7:0] sw1_o,
    input wire logic [7:0] sw2_o
);
    // ****
    // Verdict timing and status
    // ****
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Start taken only while idle
    sequence s_start;
        wr_i && addr_i == REG_START && !busy_o;
    endsequence
    sequence s_verdict;
        busy_o ##1 (done_o && !busy_o && sw1_o == SW1_FRAME);
    endsequence
    AST_START_VERDICT: assert property (s_start |=> s_verdict)
        else $error("verdict not one cycle after busy");
    AST_BUSY_SINGLE: assert property (busy_o |=> !busy_o)
        else $error("busy longer than one cycle");
    AST_DONE_CAUSE: assert property (done_o |-> $past(busy_o))
        else $error("done without busy");
    AST_DONE_PULSE: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    AST_COMMIT_OK: assert property (commit_o |-> done_o && sw2_o == ST_OK)
        else $error("commit on failed check");
    AST_OK_COMMIT: assert property (done_o && sw2_o == ST_OK |-> commit_o)
        else $error("success without commit");
    // Status holds between verdicts, hazard for polling software otherwise
    AST_SW_HOLD: assert property (!done_o |-> $stable(sw2_o) && $stable(sw1_o))
        else $error("status moved without verdict");
    AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read cycle");
endmodule : fsdc_checker_sva
bind fsdc_checker fsdc_checker_sva fsdc_checker_sva_i (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .busy_o(busy_o), .done_o(done_o), .commit_o(commit_o), .sw1_o(sw1_o), .sw2_o(sw2_o));
`default_nettype wire

// [test/fsdc_reader.sv]
`default_nettype none
module fsdc_reader
    import fsdc_pkg::*;
(
    input wire logic core_clk_i,
    input wire fsdc_pkg::fsdc_word_t rdata_i,
    output fsdc_pkg::fsdc_addr_t addr_o,
    output fsdc_pkg::fsdc_word_t wdata_o,
    output logic wr_o,
    output logic rd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Command fields over the register port
    // ****
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h0;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic put(input fsdc_addr_t a, input fsdc_word_t d);
        @(posedge core_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge core_clk_i);
        wr_o <= 1'b0;
    endtask : put
    // Data stands only in the cycle after the strobe
    task automatic get(input fsdc_addr_t a, output fsdc_word_t d);
        @(posedge core_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge core_clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask : get
endmodule : fsdc_reader
`default_nettype wire

// [test/fsdc_checker_tb.sv]
`default_nettype none
module fsdc_checker_tb;
    import fsdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {fsdc_addr_t a; fsdc_word_t d; logic [7:0] c;} fsdc_step_t;
    localparam logic [7:0] SKIP = 8'hff;
    logic core_clk_i;
    logic sys_rst_i;
    fsdc_addr_t addr;
    fsdc_word_t wdata;
    fsdc_word_t rdata;
    fsdc_word_t v;
    logic wr, rd, busy, done, commit;
    logic [7:0] sw1, sw2;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    // ****
    // Design and reader
    // ****
    fsdc_checker fsdc_checker_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .busy_o(busy), .done_o(done), .commit_o(commit), .sw1_o(sw1), .sw2_o(sw2));
    fsdc_reader fsdc_reader_i (.core_clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    task automatic check(input string what, input fsdc_word_t seen, input fsdc_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // One field write, then a check whose verdict lands one cycle after busy
    task automatic step(input fsdc_step_t s);
        fsdc_reader_i.put(s.a, s.d);
        if (s.c != SKIP) begin
            fsdc_reader_i.put(REG_START, 32'h0);
            #1;
            check("busy", {31'h0, busy}, 32'h1);
            @(posedge core_clk_i);
            #1;
            check("done", {31'h0, done}, 32'h1);
            check("commit", {31'h0, commit}, {31'h0, s.c == ST_OK});
            check("sw", {16'h0, sw1, sw2}, {16'h0, SW1_FRAME, s.c});
            fsdc_reader_i.get(REG_STATUS, v);
            check("status", v, {14'h0, s.c == ST_OK, 1'b0, s.c, SW1_FRAME});
            $display("test %h %h end", s.a, s.d);
        end
    endtask : step
    fsdc_step_t steps[] = '{
        '{REG_FILE_LEN, 32'h100, SKIP}, '{REG_CTR_OFS, 32'h10, SKIP},
        '{REG_MAC_OFS, 32'h40, SKIP}, '{REG_OPTIONS, 32'he0fec0, SKIP},
        '{REG_CONTEXT, 32'h20c, ST_OK},
        '{REG_CONTEXT, 32'h20d, ST_ABORTED},
        '{REG_CONTEXT, 32'h20e, ST_INTEGRITY},
        '{REG_CONTEXT, 32'h30c, ST_DENIED},
        '{REG_CONTEXT, 32'h208, ST_AUTH},
        '{REG_CONTEXT, 32'h20c, ST_OK}, '{REG_ACCESS, 32'h5000, ST_PARAM},
        '{REG_ACCESS, 32'h0, ST_OK}, '{REG_OPTIONS, 32'he5fec0, ST_PARAM},
        '{REG_OPTIONS, 32'hf0fec0, ST_PARAM},
        '{REG_OPTIONS, 32'he0ff00, ST_PARAM},
        '{REG_OPTIONS, 32'he0fe80, ST_PARAM},
        '{REG_OPTIONS, 32'he0fec0, ST_OK}, '{REG_MAC_OFS, 32'h8, ST_PARAM},
        '{REG_MAC_OFS, 32'h12, ST_PARAM},
        '{REG_MAC_OFS, 32'hf1, ST_PARAM},
        '{REG_MAC_OFS, 32'hf0, ST_OK},
        '{REG_MACIN_OFS, 32'hf1, ST_PARAM},
        '{REG_MACIN_OFS, 32'hf0, ST_OK},
        '{REG_MACIN_OFS, 32'h0, SKIP}, '{REG_CTR_OFS, 32'hd, ST_PARAM},
        '{REG_CTR_OFS, 32'he, ST_OK},
        '{REG_ENC_OFS, 32'h20, SKIP}, '{REG_ENC_LEN, 32'h20, SKIP},
        '{REG_OPTIONS, 32'he0fed0, ST_OK},
        '{REG_ENC_LEN, 32'h30, ST_PARAM},
        '{REG_ENC_LEN, 32'h0, ST_PARAM},
        '{REG_ENC_LEN, 32'h20, SKIP}, '{REG_MAC_OFS, 32'h3f, ST_PARAM},
        '{REG_MAC_OFS, 32'h40, ST_OK},
        '{REG_ENC_OFS, 32'h8, ST_PARAM},
        '{REG_ENC_OFS, 32'h12, ST_PARAM},
        '{REG_ENC_OFS, 32'h20, SKIP},
        '{REG_OPTIONS, 32'h00fed0, ST_OK},
        '{REG_TAG_OFS, 32'h48, ST_PARAM},
        '{REG_TAG_OFS, 32'h10, ST_PARAM},
        '{REG_TAG_OFS, 32'he1, ST_PARAM},
        '{REG_TAG_OFS, 32'he0, ST_OK},
        '{REG_OPTIONS, 32'he0fe50, ST_PARAM},
        '{REG_OPTIONS, 32'he0fef0, ST_PARAM},
        '{REG_CTR_LIMIT, 32'h1, ST_OK},
        '{REG_CUR_CTR, 32'h1, ST_PARAM},
        '{REG_OPTIONS, 32'he0ffa0, ST_PARAM}
    };
    initial begin
        sys_rst_i = 1'b1;
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        fsdc_reader_i.get(REG_COMMITTED, v);
        check("reset committed", v, 32'h00ffff00);
        fsdc_reader_i.get(8'h40, v);
        check("unmapped", v, 32'h0);
        fsdc_reader_i.put(REG_STATUS, 32'hffffffff);
        fsdc_reader_i.get(REG_STATUS, v);
        check("status read only", v, 32'h0);
        $display("test reset end");
        foreach (steps[i]) begin
            step(steps[i]);
        end
        // Failed checks since the last pass must leave this untouched
        fsdc_reader_i.get(REG_COMMITTED, v);
        check("committed", v, 32'h00e0fef0);
        $display("test commit end");
        print_verdict();
    end
endmodule : fsdc_checker_tb
`default_nettype wire
